// ==== common/tcp_pkg.sv ====
// Constants shared by the 16-bit CLEAR_ON_MATCH_MODE / fast PWM timer.
package tcp_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned NCH = 2;
  localparam int unsigned PRE_W = 10;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_CMPA = 8'h08;
  localparam logic [7:0] ADDR_CMPB = 8'h0c;
  localparam logic [7:0] ADDR_CAPT = 8'h10;
  localparam logic [7:0] ADDR_FLAGS = 8'h14;

  // Control register fields.
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_ACTA_LSB = 4;
  localparam int unsigned CTRL_ACTB_LSB = 6;
  localparam int unsigned CTRL_CSEL_LSB = 8;
  localparam int unsigned CTRL_DIRA_BIT = 12;
  localparam int unsigned CTRL_DIRB_BIT = 13;
  localparam int unsigned CTRL_PORTA_BIT = 14;
  localparam int unsigned CTRL_PORTB_BIT = 15;
  localparam int unsigned CTRL_W = 16;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // Flag register bits; software clears by writing one.
  localparam int unsigned FLG_OVF = 0;
  localparam int unsigned FLG_CMPA = 1;
  localparam int unsigned FLG_CMPB = 2;
  localparam int unsigned FLG_CAPT = 3;
  localparam int unsigned FLG_W = 4;
  localparam int unsigned WAVE_RD_LSB = 8;

  // Waveform mode codes.
  localparam logic [3:0] MODE_CTC_CMPA = 4'h4;
  localparam logic [3:0] MODE_FPWM_8 = 4'h5;
  localparam logic [3:0] MODE_FPWM_9 = 4'h6;
  localparam logic [3:0] MODE_FPWM_10 = 4'h7;
  localparam logic [3:0] MODE_CTC_CAPT = 4'hc;
  localparam logic [3:0] MODE_FPWM_CAPT = 4'he;
  localparam logic [3:0] MODE_FPWM_CMPA = 4'hf;

  localparam logic [15:0] TOP_8 = 16'h00ff;
  localparam logic [15:0] TOP_9 = 16'h01ff;
  localparam logic [15:0] TOP_10 = 16'h03ff;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;

  // Output action codes.
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // Prescale selections and the terminal count of each.
  localparam logic [2:0] CSEL_STOP = 3'h0;
  localparam logic [2:0] CSEL_DIV1 = 3'h1;
  localparam logic [2:0] CSEL_DIV8 = 3'h2;
  localparam logic [2:0] CSEL_DIV64 = 3'h3;
  localparam logic [2:0] CSEL_DIV256 = 3'h4;
  localparam logic [2:0] CSEL_DIV1024 = 3'h5;
  localparam logic [9:0] LIM_DIV1 = 10'h000;
  localparam logic [9:0] LIM_DIV8 = 10'h007;
  localparam logic [9:0] LIM_DIV64 = 10'h03f;
  localparam logic [9:0] LIM_DIV256 = 10'h0ff;
  localparam logic [9:0] LIM_DIV1024 = 10'h3ff;

  // Clock of the block, in ns.
  localparam int unsigned CLK_PERIOD_NS = 25;

endpackage

// ==== rtl/tcp_prescale.sv ====
// Prescaler that issues the timer clock enable once every N I/O clocks.
`timescale 1ns/1ps
module tcp_prescale
  import tcp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [2:0] sel,
  output logic tick
);

  typedef struct packed {
    logic [PRE_W-1:0] cnt;
  } tcp_pre_state_t;

  tcp_pre_state_t s_q;
  tcp_pre_state_t s_d;
  logic [PRE_W-1:0] lim;

  always_comb begin
    case (sel)
      CSEL_DIV1: lim = LIM_DIV1;
      CSEL_DIV8: lim = LIM_DIV8;
      CSEL_DIV64: lim = LIM_DIV64;
      CSEL_DIV256: lim = LIM_DIV256;
      CSEL_DIV1024: lim = LIM_DIV1024;
      default: lim = LIM_DIV1024;
    endcase
  end

  // A stopped or reserved selection gives no tick at all.
  assign tick = (sel != CSEL_STOP) && (sel <= CSEL_DIV1024) &&
                (s_q.cnt >= lim);

  always_comb begin
    s_d = s_q;
    if (sel == CSEL_STOP || tick) begin
      s_d.cnt = '0;
    end else begin
      s_d.cnt = PRE_W'(s_q.cnt + 1'b1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // tcp_prescale

// ==== rtl/tcp_timer16.sv ====
// 16-bit timer with clear-on-match and fast PWM waveform generation.
//
// Summary of operation
// - Modes 4/12: clear count on TOP match.
// - CLEAR_ON_MATCH_MODE: TOP match sets compare A/capture flag.
// - CLEAR_ON_MATCH_MODE TOP unbuffered; low TOP wraps via 0xFFFF.
// - CLEAR_ON_MATCH_MODE action 1 toggles output A on match.
// - Pin shows output only when direction is one.
// - CLEAR_ON_MATCH_MODE toggle period 2*N*(1+TOP) clocks.
// - Timer tick every 1/8/64/256/1024 clocks.
// - CLEAR_ON_MATCH_MODE overflow flag on MAX to zero.
// - Modes 5,6,7,14,15 count up only.
// - Fast PWM TOP: fixed, capture or compare A.
// - Fast PWM clears count tick after TOP.
// - Action 2 clear-match/set-bottom; 3 reverse.
// - Fast PWM overflow flag at TOP clear.
// - Fast PWM TOP flag with overflow flag.
// - Compare equal sets channel match flag.
// - Fixed TOP masks written compare bits.
// - Fast PWM capture TOP unbuffered, wraps.
// - Fast PWM compare buffered, loaded at TOP.
// - Compare zero spikes; compare TOP constant.
// - Fast PWM toggle only on output A in mode 15.
// - Fast PWM period N*(1+TOP) clocks.
// - Action zero leaves output state unchanged.
// - Nonzero action overrides port output value.
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module tcp_timer16
  import tcp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tcp_pkg::ADDR_W-1:0] paddr,
  input wire logic [tcp_pkg::DATA_W-1:0] pwdata,
  output logic [tcp_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic wave_a_o,
  output logic wave_a_oe,
  output logic wave_b_o,
  output logic wave_b_oe
);
  import tcp_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [CNT_W-1:0] cnt;
    logic [NCH-1:0][CNT_W-1:0] cmp_buf;
    logic [NCH-1:0][CNT_W-1:0] cmp_act;
    logic [CNT_W-1:0] capt;
    logic [FLG_W-1:0] flags;
    logic [NCH-1:0] wave;
    logic [DATA_W-1:0] rdata;
  } tcp_state_t;

  tcp_state_t s_q;
  tcp_state_t s_d;
  logic tick;
  logic [3:0] mode;
  logic [NCH-1:0][1:0] action;
  logic [CNT_W-1:0] top;
  logic fast;
  logic clear_on_match_mode;
  logic at_top;
  logic acc;
  logic wr;
  logic mapped;

  // Fast PWM: single slope, TOP restarts the count at BOTTOM.
  function automatic logic is_fast(input logic [3:0] m);
    is_fast = (m == MODE_FPWM_8) || (m == MODE_FPWM_9) ||
              (m == MODE_FPWM_10) || (m == MODE_FPWM_CAPT) ||
              (m == MODE_FPWM_CMPA);
  endfunction

  function automatic logic is_fixed(input logic [3:0] m);
    is_fixed = (m == MODE_FPWM_8) || (m == MODE_FPWM_9) ||
               (m == MODE_FPWM_10);
  endfunction

  function automatic logic [CNT_W-1:0] top_of(
    input logic [3:0] m,
    input logic [CNT_W-1:0] cmpa,
    input logic [CNT_W-1:0] cap
  );
    case (m)
      MODE_CTC_CMPA: top_of = cmpa;
      MODE_CTC_CAPT: top_of = cap;
      MODE_FPWM_8: top_of = TOP_8;
      MODE_FPWM_9: top_of = TOP_9;
      MODE_FPWM_10: top_of = TOP_10;
      MODE_FPWM_CAPT: top_of = cap;
      MODE_FPWM_CMPA: top_of = cmpa;
      default: top_of = CNT_MAX;
    endcase
  endfunction

  function automatic logic mapped_addr(input logic [ADDR_W-1:0] a);
    mapped_addr = (a == ADDR_CTRL) || (a == ADDR_COUNT) ||
                  (a == ADDR_CMPA) || (a == ADDR_CMPB) ||
                  (a == ADDR_CAPT) || (a == ADDR_FLAGS);
  endfunction

  tcp_prescale u_prescale (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sel(s_q.ctrl[CTRL_CSEL_LSB +: 3]),
    .tick(tick)
  );

  assign mode = s_q.ctrl[CTRL_MODE_LSB +: 4];
  assign action[0] = s_q.ctrl[CTRL_ACTA_LSB +: 2];
  assign action[1] = s_q.ctrl[CTRL_ACTB_LSB +: 2];
  // TOP is read from the active compare A value, so a CLEAR_ON_MATCH_MODE write takes
  // effect at once while a fast PWM write waits for the buffer load.
  assign top = top_of(mode, s_q.cmp_act[0], s_q.capt);
  assign fast = is_fast(mode);
  assign clear_on_match_mode = (mode == MODE_CTC_CMPA) || (mode == MODE_CTC_CAPT);
  assign at_top = (clear_on_match_mode || fast) && (s_q.cnt == top);

  // Zero wait states: read data is latched in the setup cycle.
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign mapped = mapped_addr(paddr);
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = s_q.rdata;

  always_comb begin
    logic [FLG_W-1:0] set;
    logic [FLG_W-1:0] clr;
    logic [CNT_W-1:0] wdat;
    logic match;
    set = '0;
    clr = '0;
    wdat = pwdata[CNT_W-1:0];
    match = 1'b0;
    s_d = s_q;

    if (tick) begin
      if (at_top) begin
        s_d.cnt = CNT_BOTTOM;
      end else begin
        // A TOP below the count is missed and the count wraps.
        s_d.cnt = CNT_W'(s_q.cnt + 1'b1);
      end
      if (fast) begin
        if (at_top) begin
          set[FLG_OVF] = 1'b1;
          s_d.cmp_act = s_q.cmp_buf;
        end
      end else if (s_q.cnt == CNT_MAX) begin
        set[FLG_OVF] = 1'b1;
      end
      if (at_top && (mode == MODE_CTC_CAPT ||
                     mode == MODE_FPWM_CAPT)) begin
        set[FLG_CAPT] = 1'b1;
      end
      if (at_top && (mode == MODE_CTC_CMPA ||
                     mode == MODE_FPWM_CMPA)) begin
        set[FLG_CMPA] = 1'b1;
      end
      for (int ch = 0; ch < NCH; ch++) begin
        match = (s_q.cnt == s_q.cmp_act[ch]);
        if (match) begin
          set[FLG_CMPA + ch] = 1'b1;
        end
        if (!fast) begin
          if (match) begin
            case (action[ch])
              ACT_TOGGLE: s_d.wave[ch] = !s_q.wave[ch];
              ACT_CLEAR: s_d.wave[ch] = 1'b0;
              ACT_SET: s_d.wave[ch] = 1'b1;
              default: s_d.wave[ch] = s_q.wave[ch];
            endcase
          end
        end else if (at_top && action[ch][1]) begin
          // The BOTTOM action wins over a match at TOP, which keeps a
          // compare value equal to TOP at a constant level.
          s_d.wave[ch] = !action[ch][0];
        end else if (match) begin
          case (action[ch])
            ACT_TOGGLE: begin
              if (ch == 0 && mode == MODE_FPWM_CMPA) begin
                s_d.wave[ch] = !s_q.wave[ch];
              end
            end
            ACT_CLEAR: s_d.wave[ch] = 1'b0;
            ACT_SET: s_d.wave[ch] = 1'b1;
            default: s_d.wave[ch] = s_q.wave[ch];
          endcase
        end
      end
    end

    if (wr) begin
      case (paddr)
        ADDR_CTRL: s_d.ctrl = pwdata[CTRL_W-1:0];
        ADDR_COUNT: s_d.cnt = wdat;
        ADDR_CMPA, ADDR_CMPB: begin
          if (is_fixed(mode)) begin
            wdat = wdat & top;
          end
          if (paddr == ADDR_CMPA) begin
            s_d.cmp_buf[0] = wdat;
            if (!fast) begin
              s_d.cmp_act[0] = wdat;
            end
          end else begin
            s_d.cmp_buf[1] = wdat;
            if (!fast) begin
              s_d.cmp_act[1] = wdat;
            end
          end
        end
        ADDR_CAPT: s_d.capt = wdat;
        ADDR_FLAGS: clr = pwdata[FLG_W-1:0];
        default: s_d.ctrl = s_q.ctrl;
      endcase
    end
    // A flag set by the timer in the clearing cycle stays set.
    s_d.flags = (s_q.flags & ~clr) | set;

    if (psel && !penable && !pwrite) begin
      s_d.rdata = '0;
      case (paddr)
        ADDR_CTRL: s_d.rdata[CTRL_W-1:0] = s_q.ctrl;
        ADDR_COUNT: s_d.rdata[CNT_W-1:0] = s_q.cnt;
        ADDR_CMPA: s_d.rdata[CNT_W-1:0] = s_q.cmp_buf[0];
        ADDR_CMPB: s_d.rdata[CNT_W-1:0] = s_q.cmp_buf[1];
        ADDR_CAPT: s_d.rdata[CNT_W-1:0] = s_q.capt;
        ADDR_FLAGS: begin
          s_d.rdata[FLG_W-1:0] = s_q.flags;
          s_d.rdata[WAVE_RD_LSB +: NCH] = s_q.wave;
        end
        default: s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Pin drivers: the waveform takes over the port value only when its
  // action is nonzero; direction always comes from the direction bit.
  assign wave_a_o = (action[0] != ACT_NONE) ? s_q.wave[0] :
                    s_q.ctrl[CTRL_PORTA_BIT];
  assign wave_b_o = (action[1] != ACT_NONE) ? s_q.wave[1] :
                    s_q.ctrl[CTRL_PORTB_BIT];
  assign wave_a_oe = s_q.ctrl[CTRL_DIRA_BIT];
  assign wave_b_oe = s_q.ctrl[CTRL_DIRB_BIT];

endmodule // tcp_timer16

// ==== dv/tcp_timer16_checker.sv ====
// Port-level assertions for the timer block, bound into its top.
`timescale 1ns/1ps
module tcp_timer16_checker
  import tcp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tcp_pkg::ADDR_W-1:0] paddr,
  input wire logic [tcp_pkg::DATA_W-1:0] pwdata,
  input wire logic [tcp_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wave_a_o,
  input wire logic wave_a_oe,
  input wire logic wave_b_o,
  input wire logic wave_b_oe
);
  logic [15:0] ctrl_q;
  logic wr;
  assign wr = psel && penable && pwrite && paddr == ADDR_CTRL;
  // Shadow of the control word, so the stopped-clock check knows the divider.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_q <= 16'h0000;
    end else if (wr) begin
      ctrl_q <= pwdata[15:0];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("pslverr outside access");
  property p_unmap;
    psel && penable && !pwrite && paddr > ADDR_FLAGS
      |-> prdata == '0 && pslverr;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_dir_a;
    wr |=> wave_a_oe == $past(pwdata[CTRL_DIRA_BIT]);
  endproperty
  a_dir_a: assert property (p_dir_a) else $error("pin A direction");
  property p_dir_b;
    wr |=> wave_b_oe == $past(pwdata[CTRL_DIRB_BIT]);
  endproperty
  a_dir_b: assert property (p_dir_b) else $error("pin B direction");
  property p_oe_hold;
    !wr |=> $stable(wave_a_oe) && $stable(wave_b_oe);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("oe moved");
  property p_port_a;
    wr && pwdata[5:4] == ACT_NONE
      |=> wave_a_o == $past(pwdata[CTRL_PORTA_BIT]);
  endproperty
  a_port_a: assert property (p_port_a) else $error("port value A");
  property p_port_b;
    wr && pwdata[7:6] == ACT_NONE
      |=> wave_b_o == $past(pwdata[CTRL_PORTB_BIT]);
  endproperty
  a_port_b: assert property (p_port_b) else $error("port value B");
  // No tick follows a stop: the divider's tick drops in the cycle the stopped selection is loaded.
  property p_stop;
    ctrl_q[10:8] == CSEL_STOP && $past(ctrl_q[10:8]) == CSEL_STOP && !wr
      |=> $stable(wave_a_o);
  endproperty
  a_stop: assert property (p_stop)
    else $error("output moved while stopped");
  c_toggle: cover property (wr && pwdata[5:4] == ACT_TOGGLE);
  c_err: cover property (pslverr);
  c_pwm: cover property ($rose(wave_a_o) && ctrl_q[3:0] == MODE_FPWM_CMPA);
endmodule // tcp_timer16_checker

bind tcp_timer16 tcp_timer16_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .wave_a_o(wave_a_o), .wave_a_oe(wave_a_oe), .wave_b_o(wave_b_o),
  .wave_b_oe(wave_b_oe));

// ==== dv/tcp_pin_load.sv ====
// Load on pin A: resolves the pin and times its high phase and period.
`timescale 1ns/1ps
module tcp_pin_load (
  input wire logic clk_sys,
  input wire logic clr,
  input wire logic drv,
  input wire logic oe,
  output logic pin,
  output logic [15:0] per,
  output logic [15:0] hi
);
  logic prev_q = 1'b0;
  logic [15:0] cnt_q = 16'h0;
  // A released pin is held low by the board's pull-down.
  assign pin = oe ? drv : 1'b0;
  always_ff @(posedge clk_sys) begin
    prev_q <= pin;
    cnt_q <= cnt_q + 16'h1;
    if (clr) begin
      per <= 16'h0;
      hi <= 16'h0;
    end else if (pin && !prev_q) begin
      per <= cnt_q;
      cnt_q <= 16'h1;
    end else if (!pin && prev_q) begin
      hi <= cnt_q;
    end
  end
endmodule // tcp_pin_load

// ==== dv/tcp_timer16_bench.sv ====
// Self-checking bench: APB set-up, pin timing and flag checks.
`timescale 1ns/1ps
`define CHK(n, x, g) begin tests_run++; if ((g) !== (x)) begin \
  bad_count++; $display("MISMATCH %s exp %0h got %0h", n, x, g); end end
module tcp_timer16_bench;
  import tcp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic clr = 1'b0;
  logic [31:0] prdata, r, w0;
  logic pready, pslverr, wa, wae, pin, e;
  logic [15:0] per, hi;
  int bad_count = 0;
  int tests_run = 0;
  tcp_timer16 dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wave_a_o(wa),
    .wave_a_oe(wae), .wave_b_o(), .wave_b_oe());
  tcp_pin_load u_load (.clk_sys(clk_sys), .clr(clr), .drv(wa), .oe(wae),
    .pin(pin), .per(per), .hi(hi));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic er);
    int n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 8'h40);
    rd = prdata;
    er = pslverr;
    if (n >= 8'h40) begin
      bad_count++;
      finish_test();
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    xfer(1'b1, a, d, rd, er);
  endtask
  task automatic zero_regs();
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, 8'(4 * i), 32'h0, r, e);
      `CHK("reset value", 32'h0, r)
    end
  endtask
  // Each run is set up with the divider stopped so it starts from count zero.
  task automatic run(input logic [3:0] m, input logic [1:0] a,
      input logic [2:0] c, input logic [15:0] ca, input logic [15:0] cp,
      input logic d, input logic [15:0] p, input logic [15:0] h,
      input logic [3:0] f);
    logic [15:0] k;
    k = {3'h0, d, 1'b0, c, 2'h0, a, m};
    wr(ADDR_CTRL, {16'h0, k & 16'hf8ff});
    wr(ADDR_COUNT, 32'h0);
    wr(ADDR_CMPA, {16'h0, ca});
    wr(ADDR_CAPT, {16'h0, cp});
    wr(ADDR_FLAGS, 32'hf);
    wr(ADDR_CTRL, {16'h0, k});
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    repeat (4 * p + 16'h28) @(posedge clk_sys);
    `CHK("period", p, per)
    `CHK("high time", h, hi)
    xfer(1'b0, ADDR_FLAGS, 32'h0, r, e);
    `CHK("flags", f, r[3:0] & 4'hb)
  endtask
  initial begin
    repeat (4'h6) @(posedge clk_sys);
    rst_n <= 1'b1;
    zero_regs();
    xfer(1'b1, 8'h40, 32'hffff, r, e);
    `CHK("write refused", 1'b1, e)
    xfer(1'b0, 8'h40, 32'h0, r, e);
    `CHK("read refused", 1'b1, e)
    `CHK("read data", 32'h0, r)
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL, 32'(MODE_FPWM_8 + i));
      wr(ADDR_CMPB, 32'hffff);
      xfer(1'b0, ADDR_CMPB, 32'h0, r, e);
      `CHK("masked compare", (32'h100 << i) - 32'h1, r)
    end
    run(4'h4,2'h1,3'h1,16'h3,16'hffff,1'b1,16'h8,16'h4,4'h2);
    run(4'hc,2'h1,3'h1,16'h2,16'h4,1'b1,16'ha,16'h5,4'ha);
    run(4'h4,2'h1,3'h1,16'h3,16'hffff,1'b0,16'h0,16'h0,4'h2);
    run(4'h4,2'h1,3'h2,16'h1,16'hffff,1'b1,16'h20,16'h10,4'h2);
    run(4'h4,2'h1,3'h3,16'h1,16'hffff,1'b1,16'h100,16'h80,4'h2);
    run(4'h4,2'h1,3'h4,16'h1,16'hffff,1'b1,16'h400,16'h200,4'h2);
    run(4'h4,2'h1,3'h5,16'h1,16'hffff,1'b1,16'h1000,16'h800,4'h2);
    run(4'h5,2'h2,3'h1,16'h40,16'hffff,1'b1,16'h100,16'h41,4'h3);
    run(4'h5,2'h3,3'h1,16'h40,16'hffff,1'b1,16'h100,16'hbf,4'h3);
    run(4'h5,2'h2,3'h1,16'h0,16'hffff,1'b1,16'h100,16'h1,4'h3);
    run(4'he,2'h2,3'h1,16'h3,16'h9,1'b1,16'ha,16'h4,4'hb);
    run(4'hf,2'h1,3'h1,16'h1,16'hffff,1'b1,16'h4,16'h2,4'h3);
    // A TOP written below the count is missed until the count wraps.
    wr(ADDR_CTRL, 32'h0004);
    wr(ADDR_COUNT, 32'hfff0);
    wr(ADDR_CMPA, 32'h3);
    wr(ADDR_FLAGS, 32'hf);
    wr(ADDR_CTRL, 32'h0104);
    repeat (8'h20) @(posedge clk_sys);
    xfer(1'b0, ADDR_FLAGS, 32'h0, r, e);
    `CHK("wrap flags", 4'h3, r[3:0] & 4'hb)
    // With action zero the matches every four ticks must leave the state
    // alone; reads three cycles apart would see a toggling state move.
    wr(ADDR_CTRL, 32'h5104);
    xfer(1'b0, ADDR_FLAGS, 32'h0, w0, e);
    for (int i = 0; i < 2; i++) begin
      xfer(1'b0, ADDR_FLAGS, 32'h0, r, e);
      `CHK("wave state", w0[8], r[8])
    end
    repeat (8'h20) @(posedge clk_sys);
    `CHK("pin level", 1'b1, pin)
    rst_n <= 1'b0;
    repeat (4'h3) @(posedge clk_sys);
    rst_n <= 1'b1;
    zero_regs();
    finish_test();
  end
endmodule // tcp_timer16_bench
